//--- src/status_field_defs.vh
// Constants for the per-packet repeater status field.
// Assumes one bit time per link clock period and a clk_sys well above it.
`ifndef STATUS_FIELD_DEFS_VH
`define STATUS_FIELD_DEFS_VH

// Field widths
`define PORT_W        4
`define ADDR_W        6
`define CBT_W         10
`define RBY_W         16
`define IBT_W         8
`define PHASE_W       3
`define STATUS_BITS   56
`define STATUS_CNT_W  6

// Limits and windows
`define CBT_MAX       10'h3FF
`define RBY_MAX       16'hFFFF
`define RBY_MISSING_DELIMITER_FLAG_MAX  16'h007F
`define IBT_MAX       8'hFF
`define CLN_WINDOW    16'h000D
`define PHASE_LAST    3'h7
`define PHASE_ZERO    3'h0
`define STATUS_LAST   6'h37
`define STATUS_FIRST  6'h00

// Sequencer states
`define ST_IDLE       2'h0
`define ST_REPEAT     2'h1
`define ST_PAD        2'h2
`define ST_STATUS     2'h3

// Synchronised input vector layout
`define IN_W          25
`define IN_BITCLK     0
`define IN_TX         1
`define IN_DATA       2
`define IN_SFD        3
`define IN_COL        4
`define IN_FAE        5
`define IN_CRC        6
`define IN_JAB        7
`define IN_ELB        8
`define IN_PLL        9
`define IN_OWC        10
`define IN_SE         11
`define IN_PCD        12
`define IN_PORT_LO    13
`define IN_PORT_HI    16
`define IN_ADDR_LO    17
`define IN_ADDR_HI    22
`define IN_SPARE_LO   23
`define IN_SPARE_HI   24

`endif

//--- src/pin_sync.v
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs change slower than a few clk_sys periods.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
  parameter W = 1
)
(
  input  wire         clk_sys,
  input  wire         reset,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);

  reg [W-1:0] stage1_r;  // Metastability catcher, read only by stage2
  reg [W-1:0] stage2_r;  // Second stage
  reg [W-1:0] stage3_r;  // Third stage

  // Shift chain; a rise is taken once stage2 and stage3 agree, a fall as soon as they differ
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      stage1_r <= {W{1'b0}};
      stage2_r <= {W{1'b0}};
      stage3_r <= {W{1'b0}};
      q_out    <= {W{1'b0}};
    end
    else
    begin
      stage1_r <= d_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      q_out    <= (q_out & ~(stage2_r ^ stage3_r)) |
                  (stage3_r & (stage2_r ~^ stage3_r));
    end
  end

endmodule // pin_sync

`default_nettype wire

//--- src/packet_status_field.v
// Builds the seven-byte per-packet status field and sends it after the
// repeated packet data on the serial management output.
// Assumes all repeater inputs are pins stable around the link clock rise,
// and that the link clock runs far slower than clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "status_field_defs.vh"

module packet_status_field
(
  input  wire                clk_sys,
  input  wire                reset,
  input  wire                bit_clk,
  input  wire                tx_active,
  input  wire                rx_data,
  input  wire                sfd_detected,
  input  wire                collision,
  input  wire                alignment_error,
  input  wire                checksum_error,
  input  wire                runaway_guard,
  input  wire                elastic_store_fault,
  input  wire                decoder_lock_loss,
  input  wire                late_contention,
  input  wire                short_event,
  input  wire                compression_done,
  input  wire [`PORT_W-1:0]  port_number_field,
  input  wire [`ADDR_W-1:0]  chip_address,
  output reg                 mgmt_carrier,
  output reg                 mgmt_data,
  output reg                 mgmt_strobe
);

  // Synchronised copies of every pin input
  wire [`IN_W-1:0]          pins_raw;
  wire [`IN_W-1:0]          pins;

  assign pins_raw = {2'b00, chip_address, port_number_field,
                     compression_done, short_event, late_contention,
                     decoder_lock_loss, elastic_store_fault,
                     runaway_guard, checksum_error, alignment_error,
                     collision, sfd_detected, rx_data, tx_active,
                     bit_clk};

  pin_sync #(.W(`IN_W)) u_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d_in    (pins_raw),
    .q_out   (pins)
  );

  // Sequencer and per-packet state
  reg [1:0]                 state_r;         // Sequencer state
  reg [1:0]                 state_nxt;
  reg                       bitclk_d_r;      // Previous bit clock level
  reg                       sfd_d_r;         // Previous delimiter level
  reg [`PHASE_W-1:0]        phase_r;         // Bit position in byte
  reg                       sfd_mode_r;      // Delimiter seen this packet
  reg                       clean_receive_flag_r;
  reg                       contention_flag_r;
  reg                       alignment_error_flag_r;
  reg                       checksum_error_flag_r;
  reg                       runaway_guard_flag_r;
  reg                       elastic_store_fault_flag_r;
  reg                       decoder_lock_loss_flag_r;
  reg                       late_contention_flag_r;
  reg                       short_event_flag_r;
  reg [`CBT_W-1:0]          first_contention_timer_r;
  reg [`RBY_W-1:0]          repeat_bytes_r;
  reg [`IBT_W-1:0]          gap_bit_timer_r;     // Running gap count
  reg [`IBT_W-1:0]          gap_capture_r;       // Gap for this packet
  reg [`STATUS_BITS-1:0]    status_shift_r;      // Outgoing field
  reg [`STATUS_CNT_W-1:0]   status_cnt_r;        // Bits already sent

  // Decoded strobes
  wire                      bit_tick;        // Link clock rising edge
  wire                      tx_now;          // Repeater transmitting
  wire                      sfd_rise;        // Delimiter just detected
  wire                      byte_done;       // Last bit of a byte
  wire                      col_now;         // Collision this bit time
  wire                      in_window;       // Clean-receive window open
  wire [`PORT_W-1:0]        port_now;
  wire [`ADDR_W-1:0]        addr_now;
  wire [`STATUS_BITS-1:0]   status_field;    // Assembled seven bytes
  wire [7:0]                status_b0;
  wire [7:0]                status_b1;
  wire [7:0]                status_b2;

  // Saturating increment used by the repeat byte counter
  function [`RBY_W-1:0] sat_inc;
    input [`RBY_W-1:0] value;
    input [`RBY_W-1:0] limit;
    begin
      sat_inc = (value >= limit) ? limit : value + 16'h0001;
    end
  endfunction

  assign bit_tick  = pins[`IN_BITCLK] & ~bitclk_d_r;
  assign tx_now    = pins[`IN_TX];
  assign sfd_rise  = pins[`IN_SFD] & ~sfd_d_r;
  assign byte_done = (phase_r == `PHASE_LAST);
  assign col_now   = pins[`IN_COL];
  assign port_now  = pins[`IN_PORT_HI:`IN_PORT_LO];
  assign addr_now  = pins[`IN_ADDR_HI:`IN_ADDR_LO];
  // Window ends with 13th post-delimiter byte, or runs to the end
  assign in_window = ~sfd_mode_r | (repeat_bytes_r < `CLN_WINDOW);

  // Status byte layouts, first byte sent first
  assign status_b0 = {addr_now, pins[`IN_PCD], 1'b0};
  assign status_b1 = {checksum_error_flag_r, alignment_error_flag_r,
                      contention_flag_r, clean_receive_flag_r,
                      port_now};
  assign status_b2 = {short_event_flag_r, late_contention_flag_r,
                      ~sfd_mode_r, decoder_lock_loss_flag_r,
                      elastic_store_fault_flag_r, runaway_guard_flag_r,
                      first_contention_timer_r[9:8]};
  assign status_field = {gap_capture_r, repeat_bytes_r[15:8],
                         repeat_bytes_r[7:0],
                         first_contention_timer_r[7:0],
                         status_b2, status_b1, status_b0};

  // Edge detectors for the link clock and the delimiter signal
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      bitclk_d_r <= 1'b0;
      sfd_d_r    <= 1'b0;
    end
    else
    begin
      bitclk_d_r <= pins[`IN_BITCLK];
      if (bit_tick)
        sfd_d_r <= pins[`IN_SFD];
    end
  end

  // Next-state logic, advanced once per bit time
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE:
        // Start of a repetition
        if (tx_now)
          state_nxt = `ST_REPEAT;
      `ST_REPEAT:
        // End of data: pad if misaligned by an alignment error
        if (!tx_now)
        begin
          if (pins[`IN_FAE] && phase_r != `PHASE_ZERO)
            state_nxt = `ST_PAD;
          else
            state_nxt = `ST_STATUS;
        end
      `ST_PAD:
        // Dummy bits until the byte closes
        if (byte_done)
          state_nxt = `ST_STATUS;
      `ST_STATUS:
        // All 56 status bits sent
        if (status_cnt_r == `STATUS_LAST)
          state_nxt = `ST_IDLE;
      default:
        state_nxt = `ST_IDLE;
    endcase
  end

  // State register
  always @(posedge clk_sys)
  begin
    if (reset)
      state_r <= `ST_IDLE;
    else if (bit_tick)
      state_r <= state_nxt;
  end

  // Per-packet flags; reloaded from the first bit when a repetition starts
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      clean_receive_flag_r       <= 1'b0;
      contention_flag_r          <= 1'b0;
      alignment_error_flag_r     <= 1'b0;
      checksum_error_flag_r      <= 1'b0;
      runaway_guard_flag_r       <= 1'b0;
      elastic_store_fault_flag_r <= 1'b0;
      decoder_lock_loss_flag_r   <= 1'b0;
      late_contention_flag_r     <= 1'b0;
      short_event_flag_r         <= 1'b0;
      sfd_mode_r                 <= 1'b0;
    end
    else if (bit_tick && state_r == `ST_IDLE && tx_now)
    begin
      // New packet: fresh flags, clean until shown otherwise
      clean_receive_flag_r       <= ~col_now;
      contention_flag_r          <= col_now;
      alignment_error_flag_r     <= 1'b0;
      checksum_error_flag_r      <= 1'b0;
      runaway_guard_flag_r       <= pins[`IN_JAB];
      elastic_store_fault_flag_r <= pins[`IN_ELB];
      decoder_lock_loss_flag_r   <= pins[`IN_PLL];
      late_contention_flag_r     <= pins[`IN_OWC];
      short_event_flag_r         <= 1'b0;
      sfd_mode_r                 <= 1'b0;
    end
    else if (bit_tick && state_r == `ST_REPEAT)
    begin
      // Early collision spoils the clean receive
      if (col_now && in_window)
        clean_receive_flag_r <= 1'b0;
      if (col_now)
        contention_flag_r <= 1'b1;
      if (pins[`IN_JAB])
        runaway_guard_flag_r <= 1'b1;
      if (pins[`IN_ELB])
        elastic_store_fault_flag_r <= 1'b1;
      if (pins[`IN_PLL])
        decoder_lock_loss_flag_r <= 1'b1;
      if (pins[`IN_OWC])
        late_contention_flag_r <= 1'b1;
      // Delimiter mode, unaffected by collisions
      if (sfd_rise)
        sfd_mode_r <= 1'b1;
      // End-of-packet verdicts sampled as transmission stops
      if (!tx_now)
      begin
        alignment_error_flag_r <= pins[`IN_FAE];
        checksum_error_flag_r  <= pins[`IN_CRC];
        short_event_flag_r     <= pins[`IN_SE];
      end
    end
  end

  // Bit phase, contention timer and repeat byte counter
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      phase_r                  <= `PHASE_ZERO;
      first_contention_timer_r <= {`CBT_W{1'b0}};
      repeat_bytes_r           <= {`RBY_W{1'b0}};
    end
    else if (bit_tick && state_r == `ST_IDLE && tx_now)
    begin
      // Preamble start is the first bit of the packet
      phase_r                  <= 3'h1;
      first_contention_timer_r <= {`CBT_W{1'b0}};
      repeat_bytes_r           <= {`RBY_W{1'b0}};
    end
    else if (bit_tick && state_r == `ST_REPEAT && tx_now)
    begin
      // Timer runs until the first collision, then holds
      if (!contention_flag_r && !col_now &&
          first_contention_timer_r != `CBT_MAX)
        first_contention_timer_r <= first_contention_timer_r +
                                    10'h001;
      if (sfd_rise)
      begin
        // Restart byte counting just after the delimiter
        phase_r        <= `PHASE_ZERO;
        repeat_bytes_r <= {`RBY_W{1'b0}};
      end
      else
      begin
        phase_r <= phase_r + 3'h1;
        if (byte_done && sfd_mode_r)
          repeat_bytes_r <= sat_inc(repeat_bytes_r, `RBY_MAX);
        else if (byte_done)
          repeat_bytes_r <= sat_inc(repeat_bytes_r,
                                    `RBY_MISSING_DELIMITER_FLAG_MAX);
      end
    end
    else if (bit_tick && state_r == `ST_PAD)
      phase_r <= phase_r + 3'h1;
  end

  // Gap timer: counts idle bit times, restarted per transmission
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      gap_bit_timer_r <= {`IBT_W{1'b0}};
      gap_capture_r   <= {`IBT_W{1'b0}};
    end
    else if (bit_tick)
    begin
      if (state_r == `ST_IDLE && tx_now)
      begin
        gap_capture_r   <= gap_bit_timer_r;
        gap_bit_timer_r <= {`IBT_W{1'b0}};
      end
      else if (!tx_now && gap_bit_timer_r != `IBT_MAX)
        gap_bit_timer_r <= gap_bit_timer_r + 8'h01;
    end
  end

  // Status shifter: loaded on the first status bit time, once the
  // end-of-packet flags latched on the last repeat bit time are settled
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      status_shift_r <= {`STATUS_BITS{1'b0}};
      status_cnt_r   <= {`STATUS_CNT_W{1'b0}};
    end
    else if (bit_tick)
    begin
      if (state_r != `ST_STATUS)
        status_cnt_r <= {`STATUS_CNT_W{1'b0}};
      else
      begin
        if (status_cnt_r == `STATUS_FIRST)
          status_shift_r <= {1'b0, status_field[`STATUS_BITS-1:1]};
        else
          status_shift_r <= {1'b0, status_shift_r[`STATUS_BITS-1:1]};
        status_cnt_r <= status_cnt_r + 6'h01;
      end
    end
  end

  // Management serial output: data, pad, then status, LSB first
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      mgmt_carrier <= 1'b0;
      mgmt_data    <= 1'b0;
      mgmt_strobe  <= 1'b0;
    end
    else
    begin
      mgmt_strobe <= 1'b0;
      if (bit_tick)
      begin
        case (state_r)
          `ST_REPEAT:
          begin
            // Repeated data passes straight through
            mgmt_carrier <= tx_now;
            mgmt_data    <= pins[`IN_DATA];
            mgmt_strobe  <= tx_now;
          end
          `ST_PAD:
          begin
            // Dummy zero bits restore byte alignment
            mgmt_carrier <= 1'b1;
            mgmt_data    <= 1'b0;
            mgmt_strobe  <= 1'b1;
          end
          `ST_STATUS:
          begin
            // Status bits, first byte first, low bit first
            mgmt_carrier <= 1'b1;
            mgmt_data    <= (status_cnt_r == `STATUS_FIRST) ?
                            status_field[0] : status_shift_r[0];
            mgmt_strobe  <= 1'b1;
          end
          default:
          begin
            mgmt_carrier <= 1'b0;
            mgmt_data    <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // packet_status_field

`default_nettype wire

//--- tb/mgmt_collector.sv
// Collector model standing at the far end of the management serial output.
// Assumes one strobe per valid bit; keeps the last 56 bits as the status.
`timescale 1ns/1ps
`default_nettype none

module mgmt_collector
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        mgmt_strobe,
  input  wire logic        mgmt_data,
  output var  logic [55:0] field_r
);
  // Bytes arrive first byte first, LSB first, so shift in from the top
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      field_r <= 56'h0;
    else if (mgmt_strobe)
      field_r <= {mgmt_data, field_r[55:1]};
  end
endmodule // mgmt_collector

`default_nettype wire

//--- tb/packet_status_field_properties.sv
// Timing checks on the management output of the status field block.
// Assumes raw pin inputs; bound to the block by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none

module status_field_checker
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic bit_clk,
  input wire logic tx_active,
  input wire logic rx_data,
  input wire logic mgmt_carrier,
  input wire logic mgmt_data,
  input wire logic mgmt_strobe
);
  logic bit_clk_r;    // Previous pin level
  logic tick_tx_r;    // tx_active seen at the last bit time
  int   since_rise_r; // Cycles since the last bit clock rise
  int   idle_ticks_r; // Bit times since tx_active was last seen high
  wire  rise = bit_clk && !bit_clk_r;

  // Helper counters from the raw pins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bit_clk_r    <= 1'b0;
      tick_tx_r    <= 1'b0;
      since_rise_r <= 63;
      idle_ticks_r <= 0;
    end
    else
    begin
      bit_clk_r <= bit_clk;
      if (rise)
        since_rise_r <= 0;
      else if (since_rise_r < 63)
        since_rise_r <= since_rise_r + 1;
      if (rise)
      begin
        tick_tx_r    <= tx_active;
        idle_ticks_r <= tx_active ? 0 : (idle_ticks_r < 127 ?
                        idle_ticks_r + 1 : idle_ticks_r);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_tick_tx;
    rise && tx_active && tick_tx_r;
  endsequence
  sequence s_strobe_soon;
    ##[2:10] mgmt_strobe;
  endsequence

  property p_strobe_pulse;
    mgmt_strobe |=> !mgmt_strobe;
  endproperty
  property p_reset_quiet;
    disable iff (1'b0)
    reset |=> !mgmt_strobe && !mgmt_carrier && !mgmt_data;
  endproperty
  property p_strobe_after_tick;
    mgmt_strobe |-> since_rise_r >= 2 && since_rise_r <= 9;
  endproperty
  property p_data_change;
    !$stable(mgmt_data) |-> since_rise_r >= 2 && since_rise_r <= 9;
  endproperty
  property p_carrier_change;
    !$stable(mgmt_carrier) |-> since_rise_r >= 2 && since_rise_r <= 9;
  endproperty
  property p_repeat_strobe;
    s_tick_tx |-> s_strobe_soon;
  endproperty
  property p_repeat_data;
    mgmt_strobe && tx_active && since_rise_r <= 7 |-> mgmt_data == rx_data;
  endproperty
  property p_idle_silent;
    mgmt_strobe |-> idle_ticks_r <= 66;
  endproperty
  property p_carrier_idle;
    idle_ticks_r > 66 |-> !mgmt_carrier;
  endproperty

  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe longer than one cycle");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active during reset");
  a_strobe_after_tick: assert property (p_strobe_after_tick)
    else $error("strobe not tied to a bit time");
  a_data_change: assert property (p_data_change)
    else $error("serial data changed without strobe");
  a_carrier_change: assert property (p_carrier_change)
    else $error("carrier changed without strobe");
  a_repeat_strobe: assert property (p_repeat_strobe)
    else $error("repeated bit not strobed");
  a_repeat_data: assert property (p_repeat_data)
    else $error("repeated bit differs from input");
  a_idle_silent: assert property (p_idle_silent)
    else $error("strobe after status end");
  a_carrier_idle: assert property (p_carrier_idle)
    else $error("carrier high while idle");
endmodule // status_field_checker

bind packet_status_field status_field_checker u_chk
(
  .clk_sys      (clk_sys),
  .reset        (reset),
  .bit_clk      (bit_clk),
  .tx_active    (tx_active),
  .rx_data      (rx_data),
  .mgmt_carrier (mgmt_carrier),
  .mgmt_data    (mgmt_data),
  .mgmt_strobe  (mgmt_strobe)
);

`default_nettype wire

//--- tb/packet_status_field_bench.sv
// Testbench for the status field block: sends packets bit by bit on the
// repeater pins and checks the status bytes the collector model gathers.
`timescale 1ns/1ps
`default_nettype none
`include "status_field_defs.vh"

module packet_status_field_bench;
  logic        clk_sys, reset, bit_clk, tx_active, rx_data;
  logic        sfd_detected, collision, compression_done;
  logic [6:0]  fl;       // {owc, decoder_lock_loss_flag, elastic_store_fault_flag, jab, se, crc, fae}
  logic [3:0]  port_sel; // Port number driven
  logic [5:0]  addr_sel; // Chip address driven
  wire         mgmt_carrier, mgmt_data, mgmt_strobe;
  wire  [`STATUS_BITS-1:0] field;
  integer      failures, checks, prev_idle, k;

  packet_status_field uut
  (
    .clk_sys(clk_sys), .reset(reset), .bit_clk(bit_clk),
    .tx_active(tx_active), .rx_data(rx_data), .sfd_detected(sfd_detected),
    .collision(collision), .alignment_error(fl[0]),
    .checksum_error(fl[1]), .short_event(fl[2]), .runaway_guard(fl[3]),
    .elastic_store_fault(fl[4]), .decoder_lock_loss(fl[5]),
    .late_contention(fl[6]), .compression_done(compression_done),
    .port_number_field(port_sel), .chip_address(addr_sel),
    .mgmt_carrier(mgmt_carrier), .mgmt_data(mgmt_data),
    .mgmt_strobe(mgmt_strobe)
  );

  mgmt_collector u_coll
  (
    .clk_sys(clk_sys), .reset(reset), .mgmt_strobe(mgmt_strobe),
    .mgmt_data(mgmt_data), .field_r(field)
  );

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One 160 ns bit time; pins change while the bit clock is low
  task send_bit(input logic tx, input logic d, input logic c,
                input logic s, input logic [6:0] f);
    @(posedge clk_sys);
    #1;
    bit_clk = 1'b0;
    tx_active = tx;
    rx_data = d;
    collision = c;
    sfd_detected = s;
    fl = f;
    repeat (8) @(posedge clk_sys);
    #1;
    bit_clk = 1'b1;
    repeat (7) @(posedge clk_sys);
  endtask

  // Packet, end bit with end flags, then idle bits
  task packet(input int nb, input int sfd_at, input int col_at,
              input logic [6:0] f, input int idle);
    int i;
    for (i = 0; i < nb; i++)
      send_bit(1'b1, i[0] ^ i[3], col_at >= 0 && i >= col_at &&
               i < col_at + 16, sfd_at >= 0 && i >= sfd_at,
               i == 120 ? (f & 7'h78) : 7'h00);
    send_bit(1'b0, 1'b0, 1'b0, sfd_at >= 0, f & 7'h07);
    for (i = 1; i < idle; i++)
      send_bit(1'b0, i[0], 1'b0, 1'b0, 7'h00);
  endtask

  // Expected status bytes worked out from the stimulus
  task check_field(input int nb, input int sfd_at, input int col_at,
                   input logic [6:0] f);
    logic        col, missing_delimiter_flag, clean_receive_flag;
    logic [15:0] rby, gap;
    col  = col_at >= 0;
    missing_delimiter_flag = sfd_at < 0;
    clean_receive_flag  = !(col && (missing_delimiter_flag || col_at - sfd_at <= 8 * `CLN_WINDOW));
    rby  = missing_delimiter_flag ? ((nb / 8 > `RBY_MISSING_DELIMITER_FLAG_MAX) ? `RBY_MISSING_DELIMITER_FLAG_MAX : nb / 8)
                : (nb - sfd_at - 1) / 8;
    gap  = (prev_idle > `IBT_MAX) ? `IBT_MAX : prev_idle;
    check(field[7:1], {addr_sel, compression_done});
    check(field[15:8], {f[1], f[0], col, clean_receive_flag, port_sel});
    check(field[23:18], {f[2], f[6], missing_delimiter_flag, f[5], f[4], f[3]});
    if (col)
      check({field[17:16], field[31:24]}, 16'(col_at - 1));
    check(field[47:32], rby);
    check(field[55:48], gap);
  endtask

  task end_of_test;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #900000;
    failures = failures + 1;
    end_of_test;
  end

  // Main sequence
  initial
  begin
    failures = 0;
    checks = 0;
    reset = 1'b1;
    bit_clk = 1'b0;
    tx_active = 1'b0;
    rx_data = 1'b0;
    sfd_detected = 1'b0;
    collision = 1'b0;
    compression_done = 1'b1;
    fl = 7'h00;
    port_sel = 4'h5;
    addr_sel = 6'h2A;
    repeat (5) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    prev_idle = 20;
    for (k = 0; k < 20; k++)
      send_bit(1'b0, k[0], 1'b0, 1'b0, 7'h00);
    packet(192, 64, -1, 7'h00, 80);
    check_field(192, 64, -1, 7'h00);
    prev_idle = 80;
    // Each flag alone; previous packet's flag must be gone
    for (k = 0; k < 7; k++)
    begin
      port_sel = k + 6;
      addr_sel = ~(6'h01 << k);
      compression_done = k[0];
      packet(k == 0 ? 197 : 192, 64, -1, 7'h01 << k, 80);
      check_field(k == 0 ? 197 : 192, 64, -1, 7'h01 << k);
    end
    // Early collision clears clean flag, late one keeps it
    packet(192, 64, 100, 7'h00, 80);
    check_field(192, 64, 100, 7'h00);
    packet(192, 64, 176, 7'h00, 300);
    check_field(192, 64, 176, 7'h00);
    prev_idle = 300;
    // No delimiter, count caps, gap saturates
    packet(1040, -1, 300, 7'h00, 80);
    check_field(1040, -1, 300, 7'h00);
    end_of_test;
  end
endmodule // packet_status_field_bench

`default_nettype wire
